// ===== logic/sil_defines.svh
// constants for the interrupt enable and cause logic
`ifndef SIL_DEFINES_SVH
`define SIL_DEFINES_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SIL_FRAME_W          16
`define SIL_ADDR_HI          15
`define SIL_ADDR_LO          14
`define SIL_RRS_BIT          13
`define SIL_RO_BIT           12
`define SIL_ADDR_IRQ         2'h1

// ----------------------------------------------------------------
// enable and cause bit positions
// ----------------------------------------------------------------
`define SIL_BIT_DOG_TIMEOUT  11
`define SIL_BIT_OVERTEMP     10
`define SIL_BIT_SPI_FAIL     8
`define SIL_BIT_BATTERY      7
`define SIL_BIT_SUPPLY       6
`define SIL_BIT_BUS_FAULT    4
`define SIL_BIT_WAKE_PIN     3
`define SIL_BIT_DOG_RESTART  2
`define SIL_BIT_BUS_EVENT    0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define SIL_DATA_MASK        12'hDDD
`define SIL_NONCRIT_MASK     12'h459
`define SIL_ENABLE_RESET     12'h000
`define SIL_CAUSE_RESET      12'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SIL_CLK_PERIOD_NS    8
`define SIL_RELEASE_TIME_NS  2000
`define SIL_RELEASE_CYCLES   ((`SIL_RELEASE_TIME_NS + `SIL_CLK_PERIOD_NS - 1) / `SIL_CLK_PERIOD_NS)

`endif

// ===== logic/sil_pkg.sv
// types for the interrupt enable and cause logic
package sil_pkg;

    // ------------------------------------------------------------
    // operating mode of the chip, supplied by mode control
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SIL_MODE_NORMAL  = 2'h0,
        SIL_MODE_FLASH   = 2'h1,
        SIL_MODE_STANDBY = 2'h2,
        SIL_MODE_OTHER   = 2'h3
    } sil_mode_t;

endpackage

// ===== logic/sil_release_timer.sv
// release timer that holds the interrupt pin high after a cause read
`timescale 1ns/10ps
`include "sil_defines.svh"

module sil_release_timer #(
    parameter int CYCLES = `SIL_RELEASE_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // control
    input  wire logic start,
    output logic      busy
);

    // ------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_reg;    // remaining release cycles

    // reload on start, otherwise count to zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= CW'(CYCLES);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - CW'(1);
        end
    end

    // busy while any count remains
    always_ff @(posedge mclk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= start || (count_reg > CW'(1));
        end
    end

endmodule

// ===== logic/sil_interrupt_logic.sv
// interrupt enable and cause logic of the system basis chip
// Function
// - battery sense falling edge gated by bit 7
// - regulator ok flag cleared, gated by bit 6
// - bus fault field change, gated by bit 4
// - wake edge interrupts in normal/flash/standby
// - disabled wake edge resets in standby only
// - restart during dog off, gated by bit 2
// - bus wake interrupts in standby, or in normal/flash unless transceiver active
// - disabled bus wake resets in standby only
// - overflow clears timeout enable every time
// - wake pin needs global wake port enable
// - cause clears on read and reset
// - events during read are never lost
// - pin released after each cause read
// - spi and battery failures signalled immediately
// - normal mode non-critical: once per period
// - address 01 with select reads causes
// - bit 11 marks standby overflow interrupt
// - bad spi clock count flags bit 8
// - timeout enable turns standby overflow into interrupt
`timescale 1ns/10ps
`include "sil_defines.svh"

module sil_interrupt_logic #(
    parameter int RELEASE_CYCLES = `SIL_RELEASE_CYCLES
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               reset_event,
    // decoded spi frame
    input  wire logic               spi_frame_valid,
    input  wire logic [15:0]        spi_frame_word,
    input  wire logic               spi_count_ok,
    output logic                    spi_reply_valid,
    output logic [15:0]             spi_reply_word,
    // chip state
    input  wire sil_pkg::sil_mode_t mode,
    input  wire logic               wake_port_enable,
    input  wire logic               dog_off,
    input  wire logic               dog_period_start,
    input  wire logic               bus_active,
    // event sources
    input  wire logic               sense_pin,
    input  wire logic               main_regulator_ok_flag,
    input  wire logic               aux_regulator_ok_flag,
    input  wire logic [1:0]         bus_fault_diag,
    input  wire logic               wake_pin,
    input  wire logic               dog_restart,
    input  wire logic               dog_overflow,
    input  wire logic               bus_wake,
    input  wire logic               overtemp_change,
    // outputs to the controller and reset logic
    output logic                    irq_out_n,
    output logic                    reset_request
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // modes in which wake sources may interrupt
    function automatic logic sil_wake_mode(input sil_pkg::sil_mode_t m);
        sil_wake_mode = (m == sil_pkg::SIL_MODE_NORMAL) ||
                        (m == sil_pkg::SIL_MODE_FLASH) ||
                        (m == sil_pkg::SIL_MODE_STANDBY);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0] enable_reg;        // interrupt enable bits
    logic [11:0] cause_reg;         // interrupt cause bits
    logic [11:0] cause_set;         // events raised this cycle
    logic        sense_prev_reg;    // previous battery sense level
    logic        main_ok_prev_reg;  // previous main regulator flag
    logic        aux_ok_prev_reg;   // previous aux regulator flag
    logic [1:0]  fault_prev_reg;    // previous bus fault field
    logic        wake_prev_reg;     // previous wake pin level
    logic        token_reg;         // normal-mode signalling allowance
    logic        nc_active_reg;     // non-critical group on the pin
    logic        release_busy;      // pin released after a read
    logic        reset_next;        // reset forced this cycle

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic frame_hit;                // good frame for this register
    logic cause_read;               // cause register is read
    logic enable_write;             // enable register is written
    logic spi_bad;                  // frame with wrong clock count

    assign frame_hit    = spi_frame_valid && spi_count_ok &&
        (spi_frame_word[`SIL_ADDR_HI:`SIL_ADDR_LO] == `SIL_ADDR_IRQ);
    assign cause_read   = frame_hit && spi_frame_word[`SIL_RRS_BIT];
    assign enable_write = frame_hit && !spi_frame_word[`SIL_RO_BIT];
    assign spi_bad      = spi_frame_valid && !spi_count_ok;

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    // previous levels of the event sources
    always_ff @(posedge mclk) begin
        if (srst) begin
            sense_prev_reg   <= 1'b1;
            main_ok_prev_reg <= 1'b1;
            aux_ok_prev_reg  <= 1'b1;
            fault_prev_reg   <= 2'h0;
            wake_prev_reg    <= 1'b1;
        end else begin
            sense_prev_reg   <= sense_pin;
            main_ok_prev_reg <= main_regulator_ok_flag;
            aux_ok_prev_reg  <= aux_regulator_ok_flag;
            fault_prev_reg   <= bus_fault_diag;
            wake_prev_reg    <= wake_pin;
        end
    end

    logic sense_fall;               // battery sense falling edge
    logic supply_lost;              // a regulator flag cleared
    logic fault_change;             // bus fault field changed
    logic wake_fall;                // qualified wake pin edge
    logic standby;                  // chip is in standby

    assign sense_fall   = sense_prev_reg && !sense_pin;
    assign supply_lost  = (main_ok_prev_reg && !main_regulator_ok_flag) ||
                          (aux_ok_prev_reg && !aux_regulator_ok_flag);
    assign fault_change = (fault_prev_reg != bus_fault_diag);
    assign wake_fall    = wake_port_enable && wake_prev_reg && !wake_pin;
    assign standby      = (mode == sil_pkg::SIL_MODE_STANDBY);

    // ------------------------------------------------------------
    // event routing
    // ------------------------------------------------------------
    // each source sets its cause bit or forces a reset
    always_comb begin
        cause_set  = 12'h000;
        reset_next = 1'b0;
        // battery failure
        if (sense_fall && enable_reg[`SIL_BIT_BATTERY]) begin
            cause_set[`SIL_BIT_BATTERY] = 1'b1;
        end
        // regulator failure
        if (supply_lost && enable_reg[`SIL_BIT_SUPPLY]) begin
            cause_set[`SIL_BIT_SUPPLY] = 1'b1;
        end
        // bus fault diagnosis change
        if (fault_change && enable_reg[`SIL_BIT_BUS_FAULT]) begin
            cause_set[`SIL_BIT_BUS_FAULT] = 1'b1;
        end
        // overtemperature warning change
        if (overtemp_change && enable_reg[`SIL_BIT_OVERTEMP]) begin
            cause_set[`SIL_BIT_OVERTEMP] = 1'b1;
        end
        // bad spi clock count
        if (spi_bad && enable_reg[`SIL_BIT_SPI_FAIL]) begin
            cause_set[`SIL_BIT_SPI_FAIL] = 1'b1;
        end
        // wake pin edge
        if (wake_fall) begin
            if (enable_reg[`SIL_BIT_WAKE_PIN]) begin
                cause_set[`SIL_BIT_WAKE_PIN] = sil_wake_mode(mode);
            end else if (standby) begin
                reset_next = 1'b1;
            end
        end
        // watchdog restart while the watchdog is off
        if (dog_restart && dog_off && enable_reg[`SIL_BIT_DOG_RESTART]) begin
            cause_set[`SIL_BIT_DOG_RESTART] = 1'b1;
        end
        // bus wake event
        if (bus_wake) begin
            if (enable_reg[`SIL_BIT_BUS_EVENT]) begin
                cause_set[`SIL_BIT_BUS_EVENT] =
                    sil_wake_mode(mode) && (standby || !bus_active);
            end else if (standby) begin
                reset_next = 1'b1;
            end
        end
        // watchdog overflow in standby
        if (dog_overflow && standby) begin
            if (enable_reg[`SIL_BIT_DOG_TIMEOUT]) begin
                cause_set[`SIL_BIT_DOG_TIMEOUT] = 1'b1;
            end else begin
                reset_next = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------
    // software write, reserved bits held at zero, overflow clear last
    always_ff @(posedge mclk) begin
        if (srst) begin
            enable_reg <= `SIL_ENABLE_RESET;
        end else begin
            if (enable_write) begin
                enable_reg <= spi_frame_word[11:0] & `SIL_DATA_MASK;
            end
            if (dog_overflow) begin
                enable_reg[`SIL_BIT_DOG_TIMEOUT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // cause register
    // ------------------------------------------------------------
    // read clears, new events in the same cycle survive
    always_ff @(posedge mclk) begin
        if (srst || reset_event) begin
            cause_reg <= `SIL_CAUSE_RESET;
        end else if (cause_read) begin
            cause_reg <= cause_set;
        end else begin
            cause_reg <= cause_reg | cause_set;
        end
    end

    // ------------------------------------------------------------
    // spi reply
    // ------------------------------------------------------------
    // reply carries header and the selected register
    always_ff @(posedge mclk) begin
        if (srst) begin
            spi_reply_valid <= 1'b0;
            spi_reply_word  <= 16'h0000;
        end else begin
            spi_reply_valid <= frame_hit;
            if (frame_hit) begin
                if (spi_frame_word[`SIL_RRS_BIT]) begin
                    spi_reply_word <= {spi_frame_word[15:12], cause_reg};
                end else begin
                    spi_reply_word <= {spi_frame_word[15:12], enable_reg};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // rate limiting of the non-critical group
    // ------------------------------------------------------------
    logic nc_pending;               // non-critical cause recorded
    logic crit_pending;             // immediate cause recorded

    assign nc_pending   = |(cause_reg & `SIL_NONCRIT_MASK);
    assign crit_pending = |(cause_reg & ~`SIL_NONCRIT_MASK);

    // allowance refilled each watchdog period
    always_ff @(posedge mclk) begin
        if (srst) begin
            token_reg <= 1'b1;
        end else if (dog_period_start) begin
            token_reg <= 1'b1;
        end else if (nc_pending && !nc_active_reg &&
                     (mode == sil_pkg::SIL_MODE_NORMAL)) begin
            token_reg <= 1'b0;
        end
    end

    // group stays on the pin until it is read away or cleared by a reset event
    always_ff @(posedge mclk) begin
        if (srst || cause_read || reset_event) begin
            nc_active_reg <= 1'b0;
        end else if (nc_pending &&
                     ((mode != sil_pkg::SIL_MODE_NORMAL) || token_reg)) begin
            nc_active_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // release timer
    // ------------------------------------------------------------
    sil_release_timer #(
        .CYCLES (RELEASE_CYCLES)
    ) u_release (
        .mclk  (mclk),
        .srst  (srst),
        .start (cause_read),
        .busy  (release_busy)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // interrupt pin, low while a signalled cause waits
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= release_busy || cause_read ||
                         !(crit_pending || nc_active_reg);
        end
    end

    // one-cycle reset request to the reset logic
    always_ff @(posedge mclk) begin
        if (srst) begin
            reset_request <= 1'b0;
        end else begin
            reset_request <= reset_next;
        end
    end

endmodule

// ===== tb/sil_props.sv
// port checker for the interrupt enable and cause logic
`timescale 1ns/10ps
module sil_props #(
    parameter int RELEASE_CYCLES = 4
) (
    // clock and reset
    input wire logic               mclk,
    input wire logic               srst,
    input wire logic               reset_event,
    // frame and reply
    input wire logic               spi_frame_valid,
    input wire logic [15:0]        spi_frame_word,
    input wire logic               spi_count_ok,
    input wire logic               spi_reply_valid,
    input wire logic [15:0]        spi_reply_word,
    // chip state and events
    input wire sil_pkg::sil_mode_t mode,
    input wire logic               sense_pin,
    input wire logic               main_regulator_ok_flag,
    input wire logic               aux_regulator_ok_flag,
    input wire logic [1:0]         bus_fault_diag,
    input wire logic               wake_pin,
    input wire logic               dog_restart,
    input wire logic               dog_overflow,
    input wire logic               bus_wake,
    input wire logic               overtemp_change,
    // outputs
    input wire logic               irq_out_n,
    input wire logic               reset_request
);
    // --------
    // helpers
    // --------
    wire       acc = spi_frame_valid && spi_count_ok && spi_frame_word[15:14] == 2'h1;
    wire       rd  = acc && spi_frame_word[13];
    wire       still = !(dog_restart | dog_overflow | bus_wake | overtemp_change);
    wire [6:0] lv  = {sense_pin, wake_pin, main_regulator_ok_flag, aux_regulator_ok_flag,
                      bus_fault_diag, 1'b0};
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // --------
    // assertions
    // --------
    a_reply_follows: assert property (acc |=> spi_reply_valid)
        else $error("reply missing after accepted frame");
    a_refused_silent: assert property (!acc |=> !spi_reply_valid)
        else $error("reply without accepted frame");
    a_reply_header: assert property (acc |=> spi_reply_word[15:12] == $past(spi_frame_word[15:12]))
        else $error("reply header differs from frame");
    a_release_hold: assert property (rd |=> irq_out_n[*4])
        else $error("pin not released after cause read");
    a_read_clears: assert property ((still && !spi_frame_valid && $stable(lv))[*2]
        ##1 (rd && still && $stable(lv)) ##1 (still && !spi_frame_valid && $stable(lv))[*6]
        |=> irq_out_n)
        else $error("pin low after read with no new event");
    a_standby_reset: assert property (reset_request |-> $past(mode) == sil_pkg::SIL_MODE_STANDBY)
        else $error("reset request outside standby");
    a_dog_reclear: assert property (dog_overflow ##1 (dog_overflow && mode == sil_pkg::SIL_MODE_STANDBY)
        |=> reset_request)
        else $error("second overflow did not reset");
    a_event_clears: assert property ((still && !spi_frame_valid && $stable(lv))[*2]
        ##1 (reset_event && still && !spi_frame_valid && $stable(lv))
        ##1 (still && !spi_frame_valid && $stable(lv))[*2] |=> irq_out_n)
        else $error("pin low after reset event");
    // main scenarios seen
    c_read: cover property (rd);
    c_reset: cover property (reset_request);
    c_pin: cover property ($fell(irq_out_n));
endmodule

bind sil_interrupt_logic sil_props #(.RELEASE_CYCLES(RELEASE_CYCLES)) props_u (
    .mclk, .srst, .reset_event, .spi_frame_valid, .spi_frame_word, .spi_count_ok,
    .spi_reply_valid, .spi_reply_word, .mode, .sense_pin, .main_regulator_ok_flag,
    .aux_regulator_ok_flag, .bus_fault_diag, .wake_pin, .dog_restart, .dog_overflow,
    .bus_wake, .overtemp_change, .irq_out_n, .reset_request);

// ===== tb/sil_mcu_model.sv
// controller model that sends frames and takes replies
`timescale 1ns/10ps
module sil_mcu_model (
    // clock
    input  wire logic        mclk,
    // frame towards the block
    output logic             spi_frame_valid,
    output logic [15:0]      spi_frame_word,
    output logic             spi_count_ok,
    // reply from the block
    input  wire logic        spi_reply_valid,
    input  wire logic [15:0] spi_reply_word
);
    initial begin
        spi_frame_valid = 1'b0;
        spi_frame_word  = 16'h0000;
        spi_count_ok    = 1'b1;
    end
    // one frame from a falling edge; returns at the falling edge after it
    task automatic xfer(input logic [15:0] w, input logic ok, output logic rv,
                        output logic [15:0] rw);
        @(negedge mclk);
        spi_frame_valid = 1'b1;
        spi_frame_word  = w & 16'hFFDD; // reserved 5 and 1 sent as zero
        spi_count_ok    = ok;
        @(negedge mclk);
        rv = spi_reply_valid;           // reply stands one cycle
        rw = spi_reply_word;
        spi_frame_valid = 1'b0;
        spi_count_ok    = 1'b1;
    endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the interrupt enable and cause logic
`timescale 1ns/10ps
module testbench;
    // --------
    // signals
    // --------
    logic               mclk = 1'b0;
    logic               srst = 1'b1;
    logic               reset_event, wake_port_enable, dog_off, dog_period_start, bus_active;
    logic               sense_pin, main_regulator_ok_flag, aux_regulator_ok_flag, wake_pin;
    logic               dog_restart, dog_overflow, bus_wake, overtemp_change;
    logic [1:0]         bus_fault_diag;
    logic               spi_frame_valid, spi_count_ok, spi_reply_valid, irq_out_n, reset_request;
    logic [15:0]        spi_frame_word, spi_reply_word;
    sil_pkg::sil_mode_t mode;
    int                 mismatches = 0;
    int                 comparisons = 0;
    int                 resets = 0;

    always #4 mclk = ~mclk;
    always @(negedge mclk) if (reset_request === 1'b1) resets++;

    sil_interrupt_logic #(.RELEASE_CYCLES(4)) dut_u (.mclk, .srst, .reset_event,
        .spi_frame_valid, .spi_frame_word, .spi_count_ok, .spi_reply_valid, .spi_reply_word,
        .mode, .wake_port_enable, .dog_off, .dog_period_start, .bus_active, .sense_pin,
        .main_regulator_ok_flag, .aux_regulator_ok_flag, .bus_fault_diag, .wake_pin,
        .dog_restart, .dog_overflow, .bus_wake, .overtemp_change, .irq_out_n, .reset_request);
    sil_mcu_model mcu_u (.mclk, .spi_frame_valid, .spi_frame_word, .spi_count_ok,
        .spi_reply_valid, .spi_reply_word);

    // --------
    // helpers
    // --------
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pin(input logic exp);
        chk("irq_out_n", 16'(irq_out_n), 16'(exp));
    endtask
    // frame that must be answered with the given word
    task automatic xf(input logic [15:0] w, input logic [15:0] exp, input string what);
        logic        rv;
        logic [15:0] rw;
        mcu_u.xfer(w, 1'b1, rv, rw);
        chk("reply valid", 16'(rv), 16'h0001);
        chk(what, rw, exp);
    endtask
    task automatic wr(input logic [11:0] d);
        logic        rv;
        logic [15:0] rw;
        mcu_u.xfer({4'h4, d}, 1'b1, rv, rw);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_regs();
        logic        rv;
        logic [15:0] rw;
        xf(16'h4FFF, 16'h4000, "enable after reset");
        xf(16'h5000, 16'h5DDD, "enable feedback");
        mcu_u.xfer(16'hB000, 1'b1, rv, rw);
        chk("refused reply", 16'(rv), 16'h0000);
        mcu_u.xfer(16'h7000, 1'b0, rv, rw);
        chk("bad count reply", 16'(rv), 16'h0000);
        xf(16'h7000, 16'h7100, "cause count fail");
        xf(16'h7000, 16'h7000, "cause cleared");
        $display("done: regs");
    endtask
    task automatic t_battery();
        wr(12'h080);
        sense_pin = 1'b0;
        cyc(3);
        pin(1'b0);
        sense_pin = 1'b1;
        cyc(1);
        fork
            xf(16'h7000, 16'h7080, "cause battery");
            begin @(negedge mclk); sense_pin = 1'b0; end
        join
        pin(1'b1);
        cyc(7);
        pin(1'b0);
        xf(16'h7000, 16'h7080, "cause kept");
        wr(12'h000);
        sense_pin = 1'b1;
        cyc(1);
        sense_pin = 1'b0;
        cyc(3);
        pin(1'b1);
        xf(16'h7000, 16'h7000, "cause battery off");
        sense_pin = 1'b1;
        $display("done: battery");
    endtask
    task automatic t_fault();
        wr(12'h450);
        main_regulator_ok_flag = 1'b0;
        bus_fault_diag = 2'h2;
        overtemp_change = 1'b1;
        cyc(1);
        overtemp_change = 1'b0;
        cyc(2);
        pin(1'b0);
        xf(16'h7000, 16'h7450, "cause supply fault");
        main_regulator_ok_flag = 1'b1;
        aux_regulator_ok_flag = 1'b0;
        bus_fault_diag = 2'h0;
        cyc(3);
        xf(16'h7000, 16'h7050, "cause aux fault");
        aux_regulator_ok_flag = 1'b1;
        $display("done: fault");
    endtask
    task automatic t_wake();
        int r0;
        for (int e = 0; e < 2; e++) begin
            for (int m = 0; m < 4; m++) begin
                mode = sil_pkg::sil_mode_t'(m[1:0]);
                wr(e ? 12'h009 : 12'h000);
                r0 = resets;
                wake_pin = 1'b0;
                cyc(2);
                wake_pin = 1'b1;
                bus_wake = 1'b1;
                cyc(1);
                bus_wake = 1'b0;
                cyc(3);
                chk("reset count", 16'(resets - r0), (e == 0 && m == 2) ? 16'h2 : 16'h0);
                xf(16'h7000, (e && m != 3) ? 16'h7009 : 16'h7000, "cause wake");
            end
        end
        mode = sil_pkg::SIL_MODE_NORMAL;
        bus_active = 1'b1;
        bus_wake = 1'b1;
        cyc(1);
        bus_wake = 1'b0;
        cyc(3);
        xf(16'h7000, 16'h7000, "cause bus active");
        bus_active = 1'b0;
        mode = sil_pkg::SIL_MODE_STANDBY;
        wr(12'h000);
        wake_port_enable = 1'b0;
        r0 = resets;
        wake_pin = 1'b0;
        cyc(3);
        chk("reset count", 16'(resets - r0), 16'h0);
        wake_pin = 1'b1;
        wake_port_enable = 1'b1;
        $display("done: wake");
    endtask
    task automatic t_dog();
        int r0;
        dog_off = 1'b1;
        wr(12'h804);
        r0 = resets;
        dog_restart = 1'b1;
        cyc(1);
        dog_restart = 1'b0;
        dog_overflow = 1'b1;
        cyc(2);
        dog_overflow = 1'b0;
        cyc(3);
        chk("reset count", 16'(resets - r0), 16'h1);
        xf(16'h7000, 16'h7804, "cause dog");
        xf(16'h5000, 16'h5004, "enable after overflow");
        dog_off = 1'b0;
        dog_restart = 1'b1;
        cyc(1);
        dog_restart = 1'b0;
        cyc(3);
        xf(16'h7000, 16'h7000, "cause dog on");
        $display("done: dog");
    endtask
    task automatic t_rate();
        mode = sil_pkg::SIL_MODE_NORMAL;
        wr(12'h040);
        dog_period_start = 1'b1;
        cyc(1);
        dog_period_start = 1'b0;
        main_regulator_ok_flag = 1'b0;
        cyc(3);
        pin(1'b0);
        main_regulator_ok_flag = 1'b1;
        xf(16'h7000, 16'h7040, "cause first");
        cyc(6);
        main_regulator_ok_flag = 1'b0;
        cyc(4);
        pin(1'b1);
        dog_period_start = 1'b1;
        cyc(1);
        dog_period_start = 1'b0;
        cyc(3);
        pin(1'b0);
        main_regulator_ok_flag = 1'b1;
        xf(16'h7000, 16'h7040, "cause limited");
        $display("done: rate");
    endtask
    task automatic t_clear();
        mode = sil_pkg::SIL_MODE_STANDBY;
        wr(12'h080);
        sense_pin = 1'b0;
        cyc(3);
        sense_pin = 1'b1;
        reset_event = 1'b1;
        cyc(1);
        reset_event = 1'b0;
        cyc(3);
        pin(1'b1);
        xf(16'h7000, 16'h7000, "cause after reset event");
        xf(16'h5000, 16'h5080, "enable kept");
        $display("done: clear");
    endtask
    // --------
    // run control
    // --------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {reset_event, dog_off, dog_period_start, bus_active, bus_wake} = 5'h00;
        {dog_restart, dog_overflow, overtemp_change} = 3'h0;
        {wake_port_enable, sense_pin, main_regulator_ok_flag} = 3'h7;
        {aux_regulator_ok_flag, wake_pin} = 2'h3;
        bus_fault_diag = 2'h0;
        mode = sil_pkg::SIL_MODE_STANDBY;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        t_regs();
        t_battery();
        t_fault();
        t_wake();
        t_dog();
        t_rate();
        t_clear();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
